// file: rtcb_defines.vh
`ifndef RTCB_DEFINES_VH
`define RTCB_DEFINES_VH

// ****************************************************************
// Register byte addresses, then the backup register word index and count.
// ****************************************************************
`define RTCB_A_TIME   13'h0000
`define RTCB_A_DATE   13'h0004
`define RTCB_A_CTRL   13'h0008
`define RTCB_A_PRESC  13'h000C
`define RTCB_A_SUBSEC 13'h0010
`define RTCB_A_ALRA   13'h0014
`define RTCB_A_ALRB   13'h0018
`define RTCB_A_ALRSS  13'h001C
`define RTCB_A_WUT    13'h0020
`define RTCB_A_STAT   13'h0024
`define RTCB_A_MASK   13'h0028
`define RTCB_A_SRAMEN 13'h002C
`define RTCB_BKP_IDX0 11'h014
`define RTCB_BKP_NUM  11'h014

// ****************************************************************
// Field positions.
// ****************************************************************
`define RTCB_C_FMT12  0
`define RTCB_C_CSEL   2:1
`define RTCB_C_ALRAE  3
`define RTCB_C_ALRBE  4
`define RTCB_C_WUTE   5
`define RTCB_C_WSEL   8:6
`define RTCB_C_CALE   9
`define RTCB_S_ALRA   0
`define RTCB_S_ALRB   1
`define RTCB_S_WUT    2

// ****************************************************************
// Reset values, fixed counts, the calibration bit and clock-select codes.
// ****************************************************************
`define RTCB_PREDIV_A 7'h7F
`define RTCB_PREDIV_S 15'h00FF
`define RTCB_WUT_RST  16'hFFFF
`define RTCB_DAY_RST  6'h01
`define RTCB_MON_RST  5'h01
`define RTCB_WDAY_RST 3'h1
`define RTCB_HSE_DIV  8'h80
`define RTCB_CAL_BIT  5
`define RTCB_CS_LSE   2'h0
`define RTCB_CS_LSI   2'h1
`define RTCB_CS_HSE   2'h2

`endif

// file: rtcb_top.v
// What this block does
// - Keep seconds to year in BCD, hours in 12 or 24 hour format.
// - Roll the date over by month length, leap years included.
// - Alarm and periodic events raise a wake interrupt.
// - Sub-second count is readable as a binary value.
// - Clock from low-speed crystal, internal RC, or fast clock over 128.
// - Drive a 512 Hz calibration output.
// - Two alarms, each calendar field maskable from the comparison.
// - 16-bit auto-reload wakeup downcounter with selectable resolution.
// - 22-bit prescaler whose reset setting yields one second from 32.768 kHz.
// - Backup SRAM of 4 Kbytes is disabled after reset until enabled.
// - Twenty 32-bit backup registers for retained storage.
// - Backup registers keep contents over system reset and standby wakeup.
// - Alarm settings, sub-seconds included, sit in 32-bit registers.
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "rtcb_defines.vh"
module rtcb_top
  #(parameter SRAM_WORDS = 1024)
  (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        sys_rst,
  input  wire        lse_clk,
  input  wire        lsi_clk,
  input  wire        hse_clk,
  input  wire [12:0] addr,
  input  wire [31:0] wr_data,
  input  wire        wr_en,
  input  wire        rd_en,
  output wire [31:0] rd_data,
  output wire        irq,
  output wire        cal_out
  );

  // ****************************************************************
  // Helper functions.
  // ****************************************************************
  // Adds one to a two-digit BCD value.
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9)
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      else
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // Returns the last BCD day of a month in a BCD year.
  function [5:0] last_day;
    input [4:0] m;
    input [7:0] y;
    reg         leap;
    begin
      leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                  : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
      case (m)
        5'h02: last_day = leap ? 6'h29 : 6'h28;
        5'h04, 5'h06, 5'h09, 5'h11: last_day = 6'h30;
        default: last_day = 6'h31;
      endcase
    end
  endfunction

  // ****************************************************************
  // Clock source sampling.
  // ****************************************************************
  reg  [2:0]  src_m_ff;
  reg  [2:0]  src_s_ff;
  reg  [2:0]  src_d_ff;
  reg  [7:0]  hse_div_ff;
  reg         rtc_tick_ff;
  reg  [1:0]  csel_ff;
  wire [2:0]  src_rise = src_s_ff & ~src_d_ff;

  // Two-flop synchronisers, then an edge detector on the second stage.
  always @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      src_m_ff <= 3'h0;
      src_s_ff <= 3'h0;
      src_d_ff <= 3'h0;
    end
    else
    begin
      src_m_ff <= {hse_clk, lsi_clk, lse_clk};
      src_s_ff <= src_m_ff;
      src_d_ff <= src_s_ff;
    end

  // Selects one source; the fast clock is divided by 128 first.
  always @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      hse_div_ff  <= 8'h00;
      rtc_tick_ff <= 1'b0;
    end
    else
    begin
      if (src_rise[2])
        hse_div_ff <= (hse_div_ff == `RTCB_HSE_DIV - 8'h01) ? 8'h00 : hse_div_ff + 8'h01;
      case (csel_ff)
        `RTCB_CS_LSE: rtc_tick_ff <= src_rise[0];
        `RTCB_CS_LSI: rtc_tick_ff <= src_rise[1];
        `RTCB_CS_HSE: rtc_tick_ff <= src_rise[2] && hse_div_ff == `RTCB_HSE_DIV - 8'h01;
        default: rtc_tick_ff <= 1'b0;
      endcase
    end

  // ****************************************************************
  // Prescaler.
  // ****************************************************************
  reg  [6:0]  prediv_a_ff;
  reg  [14:0] prediv_s_ff;
  reg  [6:0]  async_ff;
  reg  [14:0] sync_ff;
  reg         sub_tick_ff;
  wire        apre = rtc_tick_ff && async_ff == 7'h00;
  wire        sec_tick = apre && sync_ff == 15'h0000;

  // Asynchronous and synchronous stages count down and reload.
  always @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      async_ff    <= `RTCB_PREDIV_A;
      sync_ff     <= `RTCB_PREDIV_S;
      sub_tick_ff <= 1'b0;
    end
    else
    begin
      sub_tick_ff <= apre;
      if (rtc_tick_ff)
        async_ff <= apre ? prediv_a_ff : async_ff - 7'h01;
      if (apre)
        sync_ff <= sec_tick ? prediv_s_ff : sync_ff - 15'h0001;
    end

  // ****************************************************************
  // Register file state.
  // ****************************************************************
  reg  [9:0]  ctrl_ff;
  reg  [31:0] alra_ff;
  reg  [31:0] alrb_ff;
  reg  [31:0] alrss_ff;
  reg  [15:0] wut_rl_ff;
  reg  [2:0]  stat_ff;
  reg  [2:0]  mask_ff;
  reg         sram_en_ff;
  reg  [31:0] bkp_ff [0:19];
  reg  [31:0] sram [0:SRAM_WORDS-1];
  wire        wr_reg = wr_en && !addr[12];
  wire [10:0] bkp_idx = addr[12:2] - `RTCB_BKP_IDX0;
  wire        bkp_hit = !addr[12] && addr[12:2] >= `RTCB_BKP_IDX0
                        && bkp_idx < `RTCB_BKP_NUM;
  wire [9:0]  sram_idx = addr[11:2];
  integer     i;

  // Control, alarm and prescaler settings; cleared only by rst.
  always @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      ctrl_ff     <= 10'h000;
      csel_ff     <= `RTCB_CS_LSE;
      prediv_a_ff <= `RTCB_PREDIV_A;
      prediv_s_ff <= `RTCB_PREDIV_S;
      alra_ff     <= 32'h00000000;
      alrb_ff     <= 32'h00000000;
      alrss_ff    <= 32'h00000000;
      wut_rl_ff   <= `RTCB_WUT_RST;
      for (i = 0; i < 20; i = i + 1)
        bkp_ff[i] <= 32'h00000000;
    end
    else if (wr_reg)
    begin
      case (addr)
        `RTCB_A_CTRL: ctrl_ff <= wr_data[9:0];
        `RTCB_A_ALRA: alra_ff <= wr_data;
        `RTCB_A_ALRB: alrb_ff <= wr_data;
        `RTCB_A_ALRSS: alrss_ff <= wr_data;
        `RTCB_A_WUT: wut_rl_ff <= wr_data[15:0];
        `RTCB_A_PRESC:
        begin
          prediv_s_ff <= wr_data[14:0];
          prediv_a_ff <= wr_data[22:16];
        end
        default: ;
      endcase
      if (addr == `RTCB_A_CTRL)
        csel_ff <= wr_data[`RTCB_C_CSEL];
      if (bkp_hit)
        bkp_ff[bkp_idx[4:0]] <= wr_data;
    end

  // Mask and SRAM enable follow the system reset as well.
  always @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      mask_ff    <= 3'h0;
      sram_en_ff <= 1'b0;
    end
    else if (sys_rst)
    begin
      mask_ff    <= 3'h0;
      sram_en_ff <= 1'b0;
    end
    else if (wr_reg && addr == `RTCB_A_MASK)
      mask_ff <= wr_data[2:0];
    else if (wr_reg && addr == `RTCB_A_SRAMEN)
      sram_en_ff <= wr_data[0];

  // Backup SRAM keeps no reset; writes land only while enabled.
  always @(posedge sys_clk)
    if (wr_en && addr[12] && sram_en_ff)
      sram[sram_idx] <= wr_data;

  // ****************************************************************
  // Calendar.
  // ****************************************************************
  reg  [6:0]  sec_ff;
  reg  [6:0]  min_ff;
  reg  [5:0]  hour_ff;
  reg         pm_ff;
  reg  [5:0]  day_ff;
  reg  [4:0]  mon_ff;
  reg  [2:0]  wday_ff;
  reg  [7:0]  year_ff;
  wire        fmt12 = ctrl_ff[`RTCB_C_FMT12];
  wire [7:0]  sec_up = bcd_inc({1'b0, sec_ff});
  wire [7:0]  min_up = bcd_inc({1'b0, min_ff});
  wire [7:0]  hour_up = bcd_inc({2'b00, hour_ff});
  wire [7:0]  day_up = bcd_inc({2'b00, day_ff});
  wire [7:0]  mon_up = bcd_inc({3'b000, mon_ff});
  wire        sec_wrap = sec_ff == 7'h59;
  wire        min_wrap = sec_wrap && min_ff == 7'h59;
  wire        day_wrap = min_wrap && (fmt12 ? (hour_ff == 6'h11 && pm_ff) : hour_ff == 6'h23);
  wire        mon_wrap = day_wrap && day_ff == last_day(mon_ff, year_ff);
  wire        year_wrap = mon_wrap && mon_ff == 5'h12;

  // Advances on each second; a software write takes priority.
  always @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      {sec_ff, min_ff, hour_ff, pm_ff} <= 21'h000000;
      day_ff  <= `RTCB_DAY_RST;
      mon_ff  <= `RTCB_MON_RST;
      wday_ff <= `RTCB_WDAY_RST;
      year_ff <= 8'h00;
    end
    else if (wr_reg && addr == `RTCB_A_TIME)
    begin
      sec_ff  <= wr_data[6:0];
      min_ff  <= wr_data[14:8];
      hour_ff <= wr_data[21:16];
      pm_ff   <= wr_data[22];
    end
    else if (wr_reg && addr == `RTCB_A_DATE)
    begin
      day_ff  <= wr_data[5:0];
      mon_ff  <= wr_data[12:8];
      wday_ff <= wr_data[15:13];
      year_ff <= wr_data[23:16];
    end
    else if (sec_tick)
    begin
      sec_ff <= sec_wrap ? 7'h00 : sec_up[6:0];
      if (sec_wrap)
        min_ff <= (min_ff == 7'h59) ? 7'h00 : min_up[6:0];
      if (min_wrap && fmt12)
      begin
        hour_ff <= (hour_ff == 6'h12) ? 6'h01 : hour_up[5:0];
        if (hour_ff == 6'h11)
          pm_ff <= ~pm_ff;
      end
      else if (min_wrap)
        hour_ff <= (hour_ff == 6'h23) ? 6'h00 : hour_up[5:0];
      if (day_wrap)
        wday_ff <= (wday_ff == 3'h7) ? 3'h1 : wday_ff + 3'h1;
      if (day_wrap)
        day_ff <= mon_wrap ? 6'h01 : day_up[5:0];
      if (mon_wrap)
        mon_ff <= year_wrap ? 5'h01 : mon_up[4:0];
      if (year_wrap)
        year_ff <= (year_ff == 8'h99) ? 8'h00 : bcd_inc(year_ff);
    end

  // ****************************************************************
  // Alarms.
  // ****************************************************************
  // Compares one alarm word; a set mask bit drops its field, but the sub-second field is compared only while its bit 15 is set.
  function alarm_match;
    input [31:0] a;
    input [15:0] ss;
    input [14:0] cur;
    begin
      alarm_match = (a[7] || a[6:0] == sec_ff)
        && (a[15] || a[14:8] == min_ff)
        && (a[23] || (a[21:16] == hour_ff && (!fmt12 || a[22] == pm_ff)))
        && (a[31] || (a[30] ? a[26:24] == wday_ff : a[29:24] == day_ff))
        && (!ss[15] || ss[14:0] == cur);
    end
  endfunction

  wire ev_a = sub_tick_ff && ctrl_ff[`RTCB_C_ALRAE]
              && alarm_match(alra_ff, alrss_ff[15:0], sync_ff);
  wire ev_b = sub_tick_ff && ctrl_ff[`RTCB_C_ALRBE]
              && alarm_match(alrb_ff, alrss_ff[31:16], sync_ff);

  // ****************************************************************
  // Wakeup downcounter.
  // ****************************************************************
  reg  [3:0]  wdiv_ff;
  reg  [15:0] wut_ff;
  reg         wut_tick;
  wire [2:0]  wsel = ctrl_ff[`RTCB_C_WSEL];
  wire        ev_w = ctrl_ff[`RTCB_C_WUTE] && wut_tick && wut_ff == 16'h0000;

  // Picks the resolution: clock over 16, 8, 4, 2, or the second tick.
  always @*
  begin
    case (wsel)
      3'h0: wut_tick = rtc_tick_ff && wdiv_ff == 4'hF;
      3'h1: wut_tick = rtc_tick_ff && wdiv_ff[2:0] == 3'h7;
      3'h2: wut_tick = rtc_tick_ff && wdiv_ff[1:0] == 2'h3;
      3'h3: wut_tick = rtc_tick_ff && wdiv_ff[0];
      default: wut_tick = sec_tick;
    endcase
  end

  // Reloads on reaching zero; held at the reload value while off.
  always @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      wdiv_ff <= 4'h0;
      wut_ff  <= `RTCB_WUT_RST;
    end
    else
    begin
      if (rtc_tick_ff)
        wdiv_ff <= wdiv_ff + 4'h1;
      if (!ctrl_ff[`RTCB_C_WUTE])
        wut_ff <= wut_rl_ff;
      else if (wut_tick)
        wut_ff <= (wut_ff == 16'h0000) ? wut_rl_ff : wut_ff - 16'h0001;
    end

  // ****************************************************************
  // Status, interrupt and calibration output.
  // ****************************************************************
  reg  [2:0]  nxt_stat;
  reg         irq_ff;
  reg         cal_ff;

  // Events set sticky bits; a set beats a same-cycle clear.
  always @*
  begin
    nxt_stat = stat_ff;
    if (wr_reg && addr == `RTCB_A_STAT)
      nxt_stat = nxt_stat & ~wr_data[2:0];
    nxt_stat = nxt_stat | {ev_w, ev_b, ev_a};
  end

  // Interrupt is the wake request; calibration is bit 5 of the stage.
  always @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      stat_ff <= 3'h0;
      irq_ff  <= 1'b0;
      cal_ff  <= 1'b0;
    end
    else
    begin
      stat_ff <= nxt_stat;
      irq_ff  <= |(nxt_stat & mask_ff);
      cal_ff  <= ctrl_ff[`RTCB_C_CALE] && async_ff[`RTCB_CAL_BIT];
    end

  // ****************************************************************
  // Read port.
  // ****************************************************************
  reg  [31:0] rd_ff;
  reg  [31:0] nxt_rd;

  // Selects the read word; unmapped or disabled space reads zero.
  always @*
  begin
    nxt_rd = 32'h00000000;
    case (addr)
      `RTCB_A_TIME: nxt_rd = {9'h000, pm_ff, hour_ff, 1'b0, min_ff, 1'b0, sec_ff};
      `RTCB_A_DATE: nxt_rd = {8'h00, year_ff, wday_ff, mon_ff, 2'b00, day_ff};
      `RTCB_A_CTRL: nxt_rd = {22'h000000, ctrl_ff[9:3], csel_ff, ctrl_ff[0]};
      `RTCB_A_PRESC: nxt_rd = {9'h000, prediv_a_ff, 1'b0, prediv_s_ff};
      `RTCB_A_SUBSEC: nxt_rd = {17'h00000, sync_ff};
      `RTCB_A_ALRA: nxt_rd = alra_ff;
      `RTCB_A_ALRB: nxt_rd = alrb_ff;
      `RTCB_A_ALRSS: nxt_rd = alrss_ff;
      `RTCB_A_WUT: nxt_rd = {16'h0000, wut_rl_ff};
      `RTCB_A_STAT: nxt_rd = {29'h00000000, stat_ff};
      `RTCB_A_MASK: nxt_rd = {29'h00000000, mask_ff};
      `RTCB_A_SRAMEN: nxt_rd = {31'h00000000, sram_en_ff};
      default: ;
    endcase
    if (bkp_hit)
      nxt_rd = bkp_ff[bkp_idx[4:0]];
    if (addr[12] && sram_en_ff)
      nxt_rd = sram[sram_idx];
  end

  // Read data stands only in the cycle after the strobe.
  always @(posedge sys_clk or posedge rst)
    if (rst)
      rd_ff <= 32'h00000000;
    else
      rd_ff <= rd_en ? nxt_rd : 32'h00000000;

  assign rd_data = rd_ff;
  assign irq     = irq_ff;
  assign cal_out = cal_ff;

endmodule

// file: rtcb_top_assertions.sv
`timescale 1ns/1ps
`include "rtcb_defines.vh"
// ****************************************
// Port checks of the calendar block.
// ****************************************
module rtcb_chk (
  input wire        sys_clk,
  input wire        rst,
  input wire        sys_rst,
  input wire [12:0] addr,
  input wire [31:0] wr_data,
  input wire        wr_en,
  input wire        rd_en,
  input wire [31:0] rd_data,
  input wire        irq,
  input wire        cal_out
);
  reg  [2:0] mask_ff;
  reg        sram_ff;
  reg        cal_ff;
  wire       bkp;
  wire       hole;
  // Address windows of the backup registers and of the unmapped gaps.
  assign bkp  = addr >= 13'h0050 && addr <= 13'h009C;
  assign hole = (addr >= 13'h0030 && addr < 13'h0050) || (addr >= 13'h00A0 && addr < 13'h1000);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Mirrors of mask, SRAM enable and calibration enable, so gating can be judged.
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      mask_ff <= 3'h0;
      sram_ff <= 1'b0;
      cal_ff  <= 1'b0;
    end
    else
    begin
      if (sys_rst)
      begin
        mask_ff <= 3'h0;
        sram_ff <= 1'b0;
      end
      else if (wr_en && addr == `RTCB_A_MASK)
        mask_ff <= wr_data[2:0];
      else if (wr_en && addr == `RTCB_A_SRAMEN)
        sram_ff <= wr_data[0];
      if (wr_en && addr == `RTCB_A_CTRL)
        cal_ff <= wr_data[`RTCB_C_CALE];
    end
  end
  a_rd_idle_zero: assert property (!$past(rd_en) |-> rd_data == 32'h0)
    else $error("read data not zero outside a read answer");
  a_unmapped_zero: assert property (rd_en && hole |=> rd_data == 32'h0)
    else $error("unmapped address read not zero");
  a_bkp_readback: assert property (
    (wr_en && bkp) ##2 (rd_en && addr == $past(addr, 2)) |=> rd_data == $past(wr_data, 3))
    else $error("backup register read back differs");
  a_sram_off_zero: assert property (rd_en && addr[12] && !sram_ff |=> rd_data == 32'h0)
    else $error("disabled SRAM read not zero");
  a_irq_mask_gate: assert property (irq |-> $past(mask_ff) != 3'h0)
    else $error("interrupt high with every source masked");
  a_sysrst_irq_low: assert property (sys_rst |-> ##2 !irq)
    else $error("interrupt not low after system reset");
  a_cal_gated: assert property (cal_out |-> $past(cal_ff))
    else $error("calibration output active while disabled");
  a_reset_quiet: assert property ($fell(rst) |-> rd_data == 32'h0 && !irq && !cal_out)
    else $error("outputs not quiet after reset");
  c_irq: cover property ($rose(irq));
  c_cal: cover property ($rose(cal_out));
  c_bkp: cover property (rd_en && bkp);
endmodule
bind rtcb_top rtcb_chk rtcb_chk_i (.sys_clk(sys_clk), .rst(rst), .sys_rst(sys_rst), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq),
  .cal_out(cal_out));

// file: tb_top.sv
`timescale 1ns/1ps
// ****************************************
// Calendar block testbench.
// ****************************************
module tb_top;
  reg         sys_clk;
  reg         rst;
  reg         sys_rst;
  reg  [3:0]  div_ff;
  reg  [12:0] addr;
  reg  [31:0] wr_data;
  reg         wr_en;
  reg         rd_en;
  wire [31:0] rd_data;
  wire        irq;
  wire        cal_out;
  reg  [31:0] rv;
  reg  [31:0] sv;
  integer     err_count;
  integer     tests_run;
  integer     cyc;
  integer     n;
  integer     t0;
  integer     s;
  rtcb_top rtcb_top_i (.sys_clk(sys_clk), .rst(rst), .sys_rst(sys_rst), .lse_clk(div_ff[2]),
    .lsi_clk(div_ff[3]), .hse_clk(div_ff[2]), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .irq(irq), .cal_out(cal_out));
  // Clock at 200 MHz.
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Slow source clocks and the hang limit.
  always @(posedge sys_clk)
  begin
    div_ff <= div_ff + 4'h1;
    cyc = cyc + 1;
    if (cyc == 60000)
    begin
      err_count = err_count + 1;
      give_verdict;
    end
  end
  task give_verdict;
    begin
      $display("errors %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // A write is one strobe cycle; a gap cycle follows so strobes never re-arm in one step.
  task wr(input [12:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
    end
  endtask
  // A read samples the answer in the cycle after the strobe.
  task rd(input [12:0] a);
    begin
      @(posedge sys_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1;
      rv = rd_data;
    end
  endtask
  task rdc(input [12:0] a, input [31:0] e);
    begin
      rd(a);
      chk(rv, e);
    end
  endtask
  task wait_irq;
    begin
      n = 0;
      @(posedge sys_clk);
      #1;
      while (irq !== 1'b1 && n < 1000)
      begin
        @(posedge sys_clk);
        #1;
        n = n + 1;
      end
      chk({31'h0, irq}, 32'h1);
    end
  endtask
  task t_reset;
    begin
      rdc(13'h0000, 32'h0);
      rdc(13'h0004, 32'h00002101);
      rdc(13'h000C, 32'h007F00FF);
      rdc(13'h0020, 32'h0000FFFF);
      rdc(13'h1000, 32'h0);
    end
  endtask
  // Sets date and time, then waits for the next second and judges both.
  task t_roll(input [31:0] ti, input [31:0] di, input [31:0] te, input [31:0] de, input f);
    begin
      wr(13'h0008, {31'h0, f});
      wr(13'h0004, di);
      wr(13'h0000, ti);
      rv = ti;
      n = 0;
      while (rv === ti && n < 40)
      begin
        rd(13'h0000);
        n = n + 1;
      end
      chk(rv, te);
      rdc(13'h0004, de);
    end
  endtask
  task t_alarm;
    begin
      wr(13'h0028, 32'h1);
      wr(13'h0014, 32'h80808002);
      wr(13'h0018, 32'h80808003);
      wr(13'h001C, 32'h12345678);
      rdc(13'h001C, 32'h12345678);
      wr(13'h0000, 32'h0);
      wr(13'h0008, 32'h18);
      wr(13'h0024, 32'h7);
      wait_irq;
      rdc(13'h0000, 32'h2);
      rdc(13'h0024, 32'h1);
      n = 0;
      while (rv[1] !== 1'b1 && n < 40)
      begin
        rd(13'h0024);
        n = n + 1;
      end
      wr(13'h0024, 32'h1);
      rdc(13'h0024, 32'h2);
      chk({31'h0, irq}, 32'h0);
      wr(13'h0028, 32'h2);
      @(posedge sys_clk);
      #1;
      chk({31'h0, irq}, 32'h1);
    end
  endtask
  task t_wut;
    begin
      wr(13'h0008, 32'h0);
      wr(13'h0024, 32'h7);
      wr(13'h0028, 32'h4);
      wr(13'h0020, 32'h3);
      wr(13'h0008, 32'h20);
      wait_irq;
      t0 = cyc;
      wr(13'h0024, 32'h4);
      wait_irq;
      chk(cyc - t0, 32'h200);
      wr(13'h0008, 32'h0);
      wr(13'h0024, 32'h7);
    end
  endtask
  // Sub-second steps over a fixed span reveal which source clock is counted.
  task t_clk;
    begin
      wr(13'h000C, 32'h00017FFF);
      for (s = 0; s < 4; s = s + 1)
      begin
        wr(13'h0008, s << 1);
        rd(13'h0010);
        sv = rv;
        repeat (8192) @(posedge sys_clk);
        rd(13'h0010);
        rv = (sv - rv) & 32'h7FFF;
        sv = s == 0 ? 512 : s == 1 ? 256 : s == 2 ? 4 : 0;
        chk({31'h0, rv + 1 >= sv && rv <= sv + 1}, 32'h1);
      end
    end
  endtask
  task t_store;
    begin
      wr(13'h0050, 32'hA5A50001);
      rdc(13'h0050, 32'hA5A50001);
      wr(13'h009C, 32'h5A5A0013);
      rdc(13'h009C, 32'h5A5A0013);
      wr(13'h00A0, 32'hFFFFFFFF);
      rdc(13'h00A0, 32'h0);
      wr(13'h1000, 32'h12345678);
      rdc(13'h1000, 32'h0);
      wr(13'h002C, 32'h1);
      wr(13'h1FFC, 32'h9ABCDEF0);
      rdc(13'h1FFC, 32'h9ABCDEF0);
      wr(13'h0028, 32'h7);
      rd(13'h0004);
      sv = rv;
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      @(posedge sys_clk);
      sys_rst <= 1'b0;
      rdc(13'h009C, 32'h5A5A0013);
      rdc(13'h002C, 32'h0);
      rdc(13'h1FFC, 32'h0);
      rdc(13'h0004, sv);
      wr(13'h002C, 32'h1);
      rdc(13'h1FFC, 32'h9ABCDEF0);
      @(posedge sys_clk);
      rst <= 1'b1;
      @(posedge sys_clk);
      rst <= 1'b0;
      rdc(13'h0004, 32'h00002101);
    end
  endtask
  // Default prescaler: calibration output rises once per 512 cycles here.
  task t_cal;
    begin
      wr(13'h0008, 32'h200);
      n = 0;
      sv = 32'h0;
      repeat (2048)
      begin
        @(posedge sys_clk);
        #1;
        if (cal_out === 1'b1 && sv[0] === 1'b0)
          n = n + 1;
        sv = {31'h0, cal_out};
      end
      chk({31'h0, n >= 3 && n <= 5}, 32'h1);
    end
  endtask
  // Main sequence.
  initial
  begin
    rst = 1'b1;
    sys_rst = 1'b0;
    div_ff = 4'h0;
    addr = 13'h0;
    wr_data = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    err_count = 0;
    tests_run = 0;
    cyc = 0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    wr(13'h000C, 32'h00010001);
    // The counters only reload at zero, so the long reset count must drain first.
    repeat (5300) @(posedge sys_clk);
    t_roll(32'h00235959, 32'h00246228, 32'h0, 32'h00248229, 1'b0);
    t_roll(32'h00235959, 32'h00248229, 32'h0, 32'h0024A301, 1'b0);
    t_roll(32'h00235959, 32'h0023E228, 32'h0, 32'h00232301, 1'b0);
    t_roll(32'h00235959, 32'h00232430, 32'h0, 32'h00234501, 1'b0);
    t_roll(32'h00235959, 32'h00995231, 32'h0, 32'h00006101, 1'b0);
    t_roll(32'h00095959, 32'h00002101, 32'h00100000, 32'h00002101, 1'b0);
    t_roll(32'h00115959, 32'h00002101, 32'h00520000, 32'h00002101, 1'b1);
    t_roll(32'h00515959, 32'h00002101, 32'h00120000, 32'h00004102, 1'b1);
    t_roll(32'h00525959, 32'h00002101, 32'h00410000, 32'h00002101, 1'b1);
    t_alarm;
    t_wut;
    t_clk;
    t_store;
    t_cal;
    give_verdict;
  end
endmodule
